/* File: rtl/mcr_pkg.sv */
// Package for the microcontroller control register bank: data-space
// offsets, field positions, reset values and divider codes.
// Assumes an 8-bit data address space and an 8-bit data bus.
package mcr_pkg;

  localparam logic [7:0] MCR_RAM_BASE = 8'h00;
  localparam logic [7:0] MCR_RAM_TOP_SMALL = 8'h2f;
  localparam logic [7:0] MCR_RAM_TOP_LARGE = 8'h6f;
  localparam logic [7:0] MCR_HOLE_TOP = 8'h7f;
  localparam logic [7:0] MCR_REGRAM_BASE = 8'hf0;

  localparam logic [7:0] MCR_WAKE_EDGE_SELECT = 8'hc8;
  localparam logic [7:0] MCR_WAKE_ENABLE = 8'hc9;
  localparam logic [7:0] MCR_WAKE_PENDING = 8'hca;
  localparam logic [7:0] MCR_SECOND_CONTROL = 8'hcc;
  localparam logic [7:0] MCR_SUPERVISOR_RESET_CTL = 8'hcd;
  localparam logic [7:0] MCR_SUPERVISOR_COUNT = 8'hce;
  localparam logic [7:0] MCR_MODULATOR_RELOAD = 8'hcf;
  localparam logic [7:0] MCR_PORT_L_DATA = 8'hd0;
  localparam logic [7:0] MCR_PORT_L_CONFIG = 8'hd1;
  localparam logic [7:0] MCR_PORT_L_PINS = 8'hd2;
  localparam logic [7:0] MCR_PORT_G_DATA = 8'hd4;
  localparam logic [7:0] MCR_PORT_G_CONFIG = 8'hd5;
  localparam logic [7:0] MCR_PORT_G_PINS = 8'hd6;
  localparam logic [7:0] MCR_PORT_I_PINS = 8'hd7;
  localparam logic [7:0] MCR_PORT_D_DATA = 8'hdc;
  localparam logic [7:0] MCR_SERIAL_SHIFT = 8'he9;
  localparam logic [7:0] MCR_TIMER_COUNT_LOW = 8'hea;
  localparam logic [7:0] MCR_TIMER_COUNT_HIGH = 8'heb;
  localparam logic [7:0] MCR_TIMER_RELOAD_LOW = 8'hec;
  localparam logic [7:0] MCR_TIMER_RELOAD_HIGH = 8'hed;
  localparam logic [7:0] MCR_TIMER_SERIAL_CONTROL = 8'hee;
  localparam logic [7:0] MCR_PROCESSOR_STATUS_WORD = 8'hef;
  localparam logic [7:0] MCR_SECOND_POINTER_REG = 8'hfc;
  localparam logic [7:0] MCR_STACK_POINTER = 8'hfd;
  localparam logic [7:0] MCR_FIRST_POINTER_REG = 8'hfe;

  // timer_serial_control fields
  localparam int MCR_TSC_RUN = 4;
  localparam int MCR_TSC_PIN_SEL = 3;
  localparam int MCR_TSC_EDGE = 2;
  localparam int MCR_TSC_DIV_HI = 1;
  // processor_status_word fields
  localparam int MCR_PSW_HALF_CARRY = 7;
  localparam int MCR_PSW_CARRY = 6;
  localparam int MCR_PSW_TPEND = 5;
  localparam int MCR_PSW_TEN = 4;
  localparam int MCR_PSW_XPEND = 3;
  localparam int MCR_PSW_BUSY = 2;
  localparam int MCR_PSW_XEN = 1;
  localparam int MCR_PSW_GIE = 0;
  // second_control fields
  localparam int MCR_SC2_CMP_LEVEL = 3;
  localparam int MCR_SC2_UNDERFLOW = 1;
  // Writable bits of second_control: 7..4 and 2
  localparam logic [7:0] MCR_SC2_WMASK = 8'hf4;

  localparam logic [7:0] MCR_RESET_BYTE = 8'h00;
  localparam logic [7:0] MCR_ALL_ONES = 8'hff;
  localparam logic [15:0] MCR_TIMER_RESET = 16'hffff;
  localparam logic [1:0] MCR_DIV_BY2 = 2'h0;
  localparam logic [2:0] MCR_DIV2_LAST = 3'h1;
  localparam logic [2:0] MCR_DIV4_LAST = 3'h3;
  localparam logic [2:0] MCR_DIV8_LAST = 3'h7;

  // Flag-update operations issued by the core's ALU
  typedef enum logic [2:0] {
    MCR_FLAG_NONE = 3'h0,
    MCR_FLAG_SET = 3'h1,
    MCR_FLAG_RESET = 3'h2,
    MCR_FLAG_ALU = 3'h3
  } mcr_flag_op_t;

endpackage

/* File: rtl/mcr_regs.sv */
// Control and status registers plus data-space decode of the core.
// Assumes a single-cycle data bus from the core on ref_clk; reads are
// combinational from addr, writes take effect at the clock edge.
`timescale 1ns/1ns

module mcr_regs
  import mcr_pkg::*;
#(
  parameter bit LARGE_RAM = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  output logic [7:0] rdata,
  input wire mcr_flag_op_t flag_op,
  input wire logic alu_carry,
  input wire logic alu_half_carry,
  input wire logic int_ack,
  input wire logic int_return,
  input wire logic ext_int_pin,
  input wire logic capture_edge,
  input wire logic shifter_busy,
  input wire logic supervisor_underflow,
  input wire logic comparator_in,
  input wire logic [7:0] port_l_in,
  input wire logic [7:0] port_g_in,
  input wire logic [7:0] port_i_in,
  output logic int_request,
  output logic timer_run,
  output logic [2:0] timer_mode,
  output logic serial_pin_select,
  output logic serial_clk_en,
  output logic [15:0] timer_value,
  output logic [2:0] mod_ctrl,
  output logic comparator_enable,
  output logic comparator_out_enable,
  output logic supervisor_reset_enable,
  output logic [7:0] port_l_data,
  output logic [7:0] port_l_config,
  output logic [7:0] port_g_data,
  output logic [7:0] port_g_config,
  output logic [7:0] port_d_data
);

  ////////////////////////////////////////////////////////////////////////
  // Storage and synchronisers
  logic [7:0] ram [0:111];
  logic [7:0] regram [0:15];
  logic [7:0] timer_serial_control;
  logic [7:0] wake_edge_select, wake_enable, wake_pending;
  logic [7:0] supervisor_count, modulator_reload, serial_shift;
  logic [7:0] timer_reload_low, timer_reload_high;
  logic [15:0] timer_count;
  logic [3:0] sc2_bits;
  logic comparator_out_enable_q;
  logic half_carry, carry, timer_int_pending, timer_int_enable;
  logic ext_int_pending, ext_int_enable, global_int_enable;
  logic wren_written;
  logic [2:0] serial_div_cnt;
  logic ext_s1, ext_s2, ext_prev;
  logic cmp_s1, cmp_s2, udf_s1, udf_s2;
  logic [7:0] pl_s1, pl_s2, pg_s1, pg_s2, pi_s1, pi_s2;
  logic [7:0] ram_top;
  logic ram_hit, hole_hit, regram_hit, ext_edge, timer_underflow;
  logic [2:0] div_last;

  always_ff @(posedge ref_clk) begin
    ext_s1 <= ext_int_pin;
    ext_s2 <= ext_s1;
    cmp_s1 <= comparator_in;
    cmp_s2 <= cmp_s1;
    udf_s1 <= supervisor_underflow;
    udf_s2 <= udf_s1;
    pl_s1 <= port_l_in;
    pl_s2 <= pl_s1;
    pg_s1 <= port_g_in;
    pg_s2 <= pg_s1;
    pi_s1 <= port_i_in;
    pi_s2 <= pi_s1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_s2;
    end
  end

  // Edge polarity select: 0 rising, 1 falling
  assign ext_edge = timer_serial_control[MCR_TSC_EDGE] ?
    (ext_prev & ~ext_s2) : (~ext_prev & ext_s2);

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  assign ram_top = LARGE_RAM ? MCR_RAM_TOP_LARGE : MCR_RAM_TOP_SMALL;
  assign ram_hit = (addr <= ram_top);
  assign hole_hit = (addr > ram_top) && (addr <= MCR_HOLE_TOP);
  assign regram_hit = (addr >= MCR_REGRAM_BASE);

  always_ff @(posedge ref_clk) begin
    if (wr_en && ram_hit) begin
      ram[addr[6:0]] <= wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        regram[i] <= MCR_RESET_BYTE;
      end
    end else if (wr_en && regram_hit) begin
      regram[addr[3:0]] <= wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Plain read/write registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      timer_serial_control <= MCR_RESET_BYTE;
      wake_edge_select <= MCR_RESET_BYTE;
      wake_enable <= MCR_RESET_BYTE;
      wake_pending <= MCR_RESET_BYTE;
      supervisor_count <= MCR_RESET_BYTE;
      modulator_reload <= MCR_RESET_BYTE;
      serial_shift <= MCR_RESET_BYTE;
      timer_reload_low <= MCR_RESET_BYTE;
      timer_reload_high <= MCR_RESET_BYTE;
      port_l_data <= MCR_RESET_BYTE;
      port_l_config <= MCR_RESET_BYTE;
      port_g_data <= MCR_RESET_BYTE;
      port_g_config <= MCR_RESET_BYTE;
      port_d_data <= MCR_RESET_BYTE;
    end else if (wr_en) begin
      case (addr)
        MCR_TIMER_SERIAL_CONTROL: timer_serial_control <= wdata;
        MCR_WAKE_EDGE_SELECT: wake_edge_select <= wdata;
        MCR_WAKE_ENABLE: wake_enable <= wdata;
        MCR_WAKE_PENDING: wake_pending <= wdata;
        MCR_SUPERVISOR_COUNT: supervisor_count <= wdata;
        MCR_MODULATOR_RELOAD: modulator_reload <= wdata;
        MCR_SERIAL_SHIFT: serial_shift <= wdata;
        MCR_TIMER_RELOAD_LOW: timer_reload_low <= wdata;
        MCR_TIMER_RELOAD_HIGH: timer_reload_high <= wdata;
        MCR_PORT_L_DATA: port_l_data <= wdata;
        MCR_PORT_L_CONFIG: port_l_config <= wdata;
        MCR_PORT_G_DATA: port_g_data <= wdata;
        MCR_PORT_G_CONFIG: port_g_config <= wdata;
        MCR_PORT_D_DATA: port_d_data <= wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timer: runs down while enabled, reloads on underflow
  assign timer_underflow = timer_run && (timer_count == 16'h0000);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      timer_count <= MCR_TIMER_RESET;
    end else if (wr_en && addr == MCR_TIMER_COUNT_LOW) begin
      timer_count[7:0] <= wdata;
    end else if (wr_en && addr == MCR_TIMER_COUNT_HIGH) begin
      timer_count[15:8] <= wdata;
    end else if (timer_underflow) begin
      timer_count <= {timer_reload_high, timer_reload_low};
    end else if (timer_run) begin
      timer_count <= timer_count - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial clock divider
  always_comb begin
    if (timer_serial_control[MCR_TSC_DIV_HI]) begin
      div_last = MCR_DIV8_LAST;
    end else if (timer_serial_control[1:0] == MCR_DIV_BY2) begin
      div_last = MCR_DIV2_LAST;
    end else begin
      div_last = MCR_DIV4_LAST;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || serial_div_cnt >= div_last) begin
      serial_div_cnt <= 3'h0;
    end else begin
      serial_div_cnt <= serial_div_cnt + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Second control and supervisor reset enable
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sc2_bits <= 4'h0;
      comparator_out_enable_q <= 1'b0;
    end else if (wr_en && addr == MCR_SECOND_CONTROL) begin
      // Bits 3, 1 and 0 are not stored from the bus
      sc2_bits <= wdata[7:4] & MCR_SC2_WMASK[7:4];
      comparator_out_enable_q <= wdata[2];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      supervisor_reset_enable <= 1'b0;
      wren_written <= 1'b0;
    end else if (wr_en && addr == MCR_SUPERVISOR_RESET_CTL
                 && !wren_written) begin
      supervisor_reset_enable <= wdata[0];
      wren_written <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status word: carry pair
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      carry <= 1'b0;
      half_carry <= 1'b0;
    end else begin
      case (flag_op)
        MCR_FLAG_SET: begin
          carry <= 1'b1;
          half_carry <= 1'b1;
        end
        MCR_FLAG_RESET: begin
          carry <= 1'b0;
          half_carry <= 1'b0;
        end
        MCR_FLAG_ALU: begin
          carry <= alu_carry;
          half_carry <= alu_half_carry;
        end
        default: begin
          if (wr_en && addr == MCR_PROCESSOR_STATUS_WORD) begin
            carry <= wdata[MCR_PSW_CARRY];
            half_carry <= wdata[MCR_PSW_HALF_CARRY];
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status word: interrupt bits; hardware set wins over software clear
  logic psw_wr;
  assign psw_wr = wr_en && (addr == MCR_PROCESSOR_STATUS_WORD);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      timer_int_pending <= 1'b0;
      ext_int_pending <= 1'b0;
    end else begin
      if (timer_underflow || capture_edge) begin
        timer_int_pending <= 1'b1;
      end else if (psw_wr) begin
        timer_int_pending <= wdata[MCR_PSW_TPEND];
      end
      if (ext_edge) begin
        ext_int_pending <= 1'b1;
      end else if (psw_wr) begin
        ext_int_pending <= wdata[MCR_PSW_XPEND];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      timer_int_enable <= 1'b0;
      ext_int_enable <= 1'b0;
      global_int_enable <= 1'b0;
    end else begin
      if (psw_wr) begin
        timer_int_enable <= wdata[MCR_PSW_TEN];
        ext_int_enable <= wdata[MCR_PSW_XEN];
      end
      if (int_ack) begin
        global_int_enable <= 1'b0;
      end else if (int_return) begin
        global_int_enable <= 1'b1;
      end else if (psw_wr) begin
        global_int_enable <= wdata[MCR_PSW_GIE];
      end
    end
  end

  assign int_request = global_int_enable && (
    (timer_int_pending && timer_int_enable) ||
    (ext_int_pending && ext_int_enable));

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign timer_run = timer_serial_control[MCR_TSC_RUN];
  assign timer_mode = timer_serial_control[7:5];
  assign serial_pin_select = timer_serial_control[MCR_TSC_PIN_SEL];
  assign serial_clk_en = (serial_div_cnt == div_last);
  assign timer_value = timer_count;
  assign mod_ctrl = sc2_bits[3:1];
  assign comparator_enable = sc2_bits[0];
  assign comparator_out_enable = comparator_out_enable_q;

  ////////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb begin
    rdata = MCR_RESET_BYTE;
    if (ram_hit) begin
      rdata = ram[addr[6:0]];
    end else if (hole_hit) begin
      rdata = MCR_ALL_ONES;
    end else if (regram_hit) begin
      rdata = regram[addr[3:0]];
    end else begin
      case (addr)
        MCR_WAKE_EDGE_SELECT: rdata = wake_edge_select;
        MCR_WAKE_ENABLE: rdata = wake_enable;
        MCR_WAKE_PENDING: rdata = wake_pending;
        MCR_SECOND_CONTROL: rdata = {sc2_bits, cmp_s2,
          comparator_out_enable_q, udf_s2, 1'b0};
        MCR_SUPERVISOR_RESET_CTL: rdata = {7'h00, supervisor_reset_enable};
        MCR_SUPERVISOR_COUNT: rdata = supervisor_count;
        MCR_MODULATOR_RELOAD: rdata = modulator_reload;
        MCR_PORT_L_DATA: rdata = port_l_data;
        MCR_PORT_L_CONFIG: rdata = port_l_config;
        MCR_PORT_L_PINS: rdata = pl_s2;
        MCR_PORT_G_DATA: rdata = port_g_data;
        MCR_PORT_G_CONFIG: rdata = port_g_config;
        MCR_PORT_G_PINS: rdata = pg_s2;
        MCR_PORT_I_PINS: rdata = pi_s2;
        MCR_PORT_D_DATA: rdata = port_d_data;
        MCR_SERIAL_SHIFT: rdata = serial_shift;
        MCR_TIMER_COUNT_LOW: rdata = timer_count[7:0];
        MCR_TIMER_COUNT_HIGH: rdata = timer_count[15:8];
        MCR_TIMER_RELOAD_LOW: rdata = timer_reload_low;
        MCR_TIMER_RELOAD_HIGH: rdata = timer_reload_high;
        MCR_TIMER_SERIAL_CONTROL: rdata = timer_serial_control;
        MCR_PROCESSOR_STATUS_WORD: rdata = {half_carry, carry,
          timer_int_pending, timer_int_enable, ext_int_pending,
          shifter_busy, ext_int_enable, global_int_enable};
        default: rdata = MCR_RESET_BYTE;
      endcase
    end
  end

endmodule

/* File: test/mcr_regs_asserts.sv */
// Concurrent checks on the control register bank ports.
// Assumes it is bound into mcr_regs and sees only its ports.
`timescale 1ns/1ns
module mcr_regs_asserts
  import mcr_pkg::*;
#(
  parameter bit LARGE_RAM = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic [7:0] rdata,
  input wire mcr_flag_op_t flag_op,
  input wire logic alu_carry,
  input wire logic alu_half_carry,
  input wire logic shifter_busy,
  input wire logic int_request,
  input wire logic timer_run,
  input wire logic [15:0] timer_value,
  input wire logic supervisor_reset_enable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [7:0] hole_lo;
  assign hole_lo = LARGE_RAM ? 8'h70 : 8'h30;
  ////////////////////////////////////////
  busy_flag_a: assert property (
    addr == MCR_PROCESSOR_STATUS_WORD && $stable(shifter_busy)
    |-> rdata[MCR_PSW_BUSY] == shifter_busy) else $error("busy bit off");
  set_carry_a: assert property (
    flag_op == MCR_FLAG_SET ##1 addr == MCR_PROCESSOR_STATUS_WORD
    |-> rdata[7:6] == 2'h3) else $error("set carry failed");
  clear_carry_a: assert property (
    flag_op == MCR_FLAG_RESET ##1 addr == MCR_PROCESSOR_STATUS_WORD
    |-> rdata[7:6] == 2'h0) else $error("reset carry failed");
  alu_flags_a: assert property (
    flag_op == MCR_FLAG_ALU ##1 addr == MCR_PROCESSOR_STATUS_WORD
    |-> rdata[7:6] == {$past(alu_half_carry), $past(alu_carry)})
    else $error("alu carry pair wrong");
  int_gate_a: assert property (
    addr == MCR_PROCESSOR_STATUS_WORD |-> int_request == (rdata[0] &&
    (rdata[5] && rdata[4] || rdata[3] && rdata[1])))
    else $error("interrupt gating wrong");
  first_write_a: assert property (
    $fell(rst) ##[0:2] (wr_en && addr == MCR_SUPERVISOR_RESET_CTL)
    |=> supervisor_reset_enable == $past(wdata[0]))
    else $error("first write not stored");
  later_write_a: assert property (
    wr_en && addr == MCR_SUPERVISOR_RESET_CTL ##2
    wr_en && addr == MCR_SUPERVISOR_RESET_CTL
    |=> $stable(supervisor_reset_enable)) else $error("second write stored");
  ctl2_write_a: assert property (
    wr_en && addr == MCR_SECOND_CONTROL ##1 addr == MCR_SECOND_CONTROL
    |-> (rdata & MCR_SC2_WMASK) == ($past(wdata) & MCR_SC2_WMASK))
    else $error("second control bits wrong");
  run_bit_a: assert property (
    wr_en && addr == MCR_TIMER_SERIAL_CONTROL
    |=> timer_run == $past(wdata[MCR_TSC_RUN])) else $error("run bit wrong");
  timer_hold_a: assert property (
    !timer_run && !wr_en |=> $stable(timer_value))
    else $error("stopped timer moved");
  hole_ones_a: assert property (
    addr >= hole_lo && addr <= MCR_HOLE_TOP |-> rdata == MCR_ALL_ONES)
    else $error("hole not all ones");
endmodule

/* File: test/mcr_core_model.sv */
// Core-side data bus model: single-cycle writes and reads.
// Assumes reads are combinational and results are handed to the bench.
`timescale 1ns/1ns
module mcr_core_model
  import mcr_pkg::*;
(
  input wire logic ref_clk,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr_en,
  input wire logic [7:0] rdata,
  output logic rd_seen,
  output logic [7:0] rd_value
);
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_seen = 1'b0;
    rd_value = 8'h00;
  end
  ////////////////////////////////////////
  // Released data is inverted so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= (a == MCR_SECOND_CONTROL) ? (d & 8'hfe) : d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    addr <= a;
    @(posedge ref_clk);
    rd_value <= rdata;
    rd_seen <= 1'b1;
    @(posedge ref_clk);
    rd_seen <= 1'b0;
  endtask
endmodule

/* File: test/tb_mcu_control_register_map.sv */
// Self-checking bench for the control register bank.
// Assumes the core model drives the data bus and expected read values go to a queue.
`timescale 1ns/1ns
module tb_mcu_control_register_map import mcr_pkg::*;;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr, wdata, rdata, rd_value, lfsr;
  logic wr_en, rd_seen, int_request, timer_run, serial_clk_en, sup_en;
  logic [15:0] timer_value;
  wire [2:0] tmode, mctl;
  wire psel, cen, coe;
  wire [39:0] pout;
  mcr_flag_op_t flag_op = MCR_FLAG_NONE;
  logic alu_carry = 1'b0, alu_half_carry = 1'b0, int_ack = 1'b0;
  logic int_return = 1'b0, ext_int_pin = 1'b0, capture_edge = 1'b0;
  logic shifter_busy = 1'b0, sup_udf = 1'b0, comparator_in = 1'b0;
  logic [7:0] pl = 8'h00, pg = 8'h00, pi = 8'h00;
  logic [7:0] exp_q[$];
  logic [7:0] regs[23] = '{8'h00, 8'h6f, 8'hc8, 8'hc9, 8'hca, 8'hce,
    8'hcf, 8'hd0, 8'hd1, 8'hd4, 8'hd5, 8'hdc, 8'he9, 8'hec, 8'hed,
    8'hf0, 8'hfc, 8'hfd, 8'hfe, 8'hff, 8'hcc, 8'hee, 8'hef};
  int num_errors = 0;
  int total_checks = 0;
  int n;
  always #2 ref_clk = ~ref_clk;
  mcr_core_model core (.ref_clk(ref_clk), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rdata(rdata), .rd_seen(rd_seen), .rd_value(rd_value));
  mcr_regs dut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rdata(rdata), .flag_op(flag_op), .alu_carry(alu_carry),
    .alu_half_carry(alu_half_carry), .int_ack(int_ack),
    .int_return(int_return), .ext_int_pin(ext_int_pin),
    .capture_edge(capture_edge), .shifter_busy(shifter_busy),
    .supervisor_underflow(sup_udf), .comparator_in(comparator_in),
    .port_l_in(pl), .port_g_in(pg), .port_i_in(pi),
    .int_request(int_request), .timer_run(timer_run), .timer_mode(tmode),
    .serial_pin_select(psel), .serial_clk_en(serial_clk_en),
    .timer_value(timer_value), .mod_ctrl(mctl), .comparator_enable(cen),
    .comparator_out_enable(coe), .supervisor_reset_enable(sup_en),
    .port_l_data(pout[7:0]), .port_l_config(pout[15:8]),
    .port_g_data(pout[23:16]), .port_g_config(pout[31:24]),
    .port_d_data(pout[39:32]));
  ////////////////////////////////////////
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    core.rd(a);
  endtask
  task automatic pulse_flag(input mcr_flag_op_t op, input logic c,
      input logic h);
    @(posedge ref_clk);
    flag_op <= op;
    alu_carry <= c;
    alu_half_carry <= h;
    @(posedge ref_clk);
    flag_op <= MCR_FLAG_NONE;
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    if (rd_seen === 1'b1 && exp_q.size() > 0) begin
      cmp({8'h00, rd_value}, {8'h00, exp_q.pop_front()});
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    test_done();
  end
  ////////////////////////////////////////
  initial begin
    lfsr = 8'd91;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    core.wr(MCR_SUPERVISOR_RESET_CTL, 8'hff);
    core.wr(MCR_SUPERVISOR_RESET_CTL, 8'h00);
    chk(MCR_SUPERVISOR_RESET_CTL, 8'h01);
    for (int i = 2; i < 23; i++) chk(regs[i], 8'h00);
    chk(MCR_TIMER_COUNT_LOW, 8'hff);
    chk(MCR_TIMER_COUNT_HIGH, 8'hff);
    for (int i = 0; i < 20; i++) begin
      lfsr = lfsr_next(lfsr);
      core.wr(regs[i], lfsr);
      chk(regs[i], lfsr);
    end
    core.wr(8'h75, 8'h00);
    chk(8'h75, 8'hff);
    chk(MCR_HOLE_TOP, 8'hff);
    pl <= lfsr;
    pg <= ~lfsr;
    pi <= lfsr ^ 8'h3c;
    core.wr(MCR_PORT_L_PINS, 8'h00);
    chk(MCR_PORT_L_PINS, lfsr);
    chk(MCR_PORT_G_PINS, ~lfsr);
    chk(MCR_PORT_I_PINS, lfsr ^ 8'h3c);
    // Port register outputs follow their writes one cycle later
    for (int i = 0; i < 5; i++) begin
      lfsr = lfsr_next(lfsr);
      core.wr(regs[i + 7], lfsr);
      @(posedge ref_clk);
      cmp({8'h00, pout[i * 8 +: 8]}, {8'h00, lfsr});
    end
    core.wr(MCR_SECOND_CONTROL, 8'hff);
    chk(MCR_SECOND_CONTROL, 8'hf4);
    cmp({11'h000, mctl, cen, coe}, 16'h001f);
    sup_udf <= 1'b1;
    comparator_in <= 1'b1;
    core.wr(MCR_SECOND_CONTROL, 8'h00);
    chk(MCR_SECOND_CONTROL, 8'h0a);
    cmp({11'h000, mctl, cen, coe}, 16'h0000);
    chk(MCR_PROCESSOR_STATUS_WORD, 8'h00);
    pulse_flag(MCR_FLAG_SET, 1'b0, 1'b0);
    chk(MCR_PROCESSOR_STATUS_WORD, 8'hc0);
    pulse_flag(MCR_FLAG_RESET, 1'b1, 1'b1);
    chk(MCR_PROCESSOR_STATUS_WORD, 8'h00);
    pulse_flag(MCR_FLAG_ALU, 1'b1, 1'b0);
    chk(MCR_PROCESSOR_STATUS_WORD, 8'h40);
    pulse_flag(MCR_FLAG_ALU, 1'b0, 1'b1);
    chk(MCR_PROCESSOR_STATUS_WORD, 8'h80);
    pulse_flag(MCR_FLAG_RESET, 1'b0, 1'b0);
    capture_edge <= 1'b1;
    shifter_busy <= 1'b1;
    @(posedge ref_clk);
    capture_edge <= 1'b0;
    chk(MCR_PROCESSOR_STATUS_WORD, 8'h24);
    cmp(int_request, 16'h0);
    core.wr(MCR_PROCESSOR_STATUS_WORD, 8'h31);
    chk(MCR_PROCESSOR_STATUS_WORD, 8'h35);
    cmp(int_request, 16'h1);
    shifter_busy <= 1'b0;
    int_ack <= 1'b1;
    @(posedge ref_clk);
    int_ack <= 1'b0;
    chk(MCR_PROCESSOR_STATUS_WORD, 8'h30);
    cmp(int_request, 16'h0);
    core.wr(MCR_PROCESSOR_STATUS_WORD, 8'h02);
    ext_int_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk(MCR_PROCESSOR_STATUS_WORD, 8'h0a);
    int_return <= 1'b1;
    @(posedge ref_clk);
    int_return <= 1'b0;
    chk(MCR_PROCESSOR_STATUS_WORD, 8'h0b);
    cmp(int_request, 16'h1);
    core.wr(MCR_TIMER_SERIAL_CONTROL, 8'h04);
    core.wr(MCR_PROCESSOR_STATUS_WORD, 8'h03);
    ext_int_pin <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(MCR_PROCESSOR_STATUS_WORD, 8'h0b);
    core.wr(MCR_TIMER_RELOAD_LOW, 8'h03);
    core.wr(MCR_TIMER_RELOAD_HIGH, 8'h00);
    core.wr(MCR_TIMER_COUNT_HIGH, 8'h00);
    core.wr(MCR_TIMER_COUNT_LOW, 8'h05);
    core.wr(MCR_PROCESSOR_STATUS_WORD, 8'h00);
    repeat (3) @(posedge ref_clk);
    cmp(timer_value, 16'h0005);
    core.wr(MCR_TIMER_SERIAL_CONTROL, 8'h10);
    n = 0;
    while (timer_value !== 16'h0000 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    cmp(16'(n), 16'h0006);
    chk(MCR_PROCESSOR_STATUS_WORD, 8'h20);
    core.wr(MCR_TIMER_SERIAL_CONTROL, 8'hec);
    @(posedge ref_clk);
    cmp({12'h000, tmode, psel}, 16'h000f);
    for (int code = 0; code < 4; code++) begin
      core.wr(MCR_TIMER_SERIAL_CONTROL, 8'(code));
      repeat (2) @(posedge ref_clk);
      n = 0;
      repeat (16) begin
        @(posedge ref_clk);
        if (serial_clk_en === 1'b1) n++;
      end
      cmp(16'(n), 16'(code > 1 ? 2 : 8 >> code));
    end
    // Second reset in mid-run re-arms the write-once enable
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    core.wr(MCR_SUPERVISOR_RESET_CTL, 8'h01);
    core.wr(MCR_SUPERVISOR_RESET_CTL, 8'h00);
    chk(MCR_SUPERVISOR_RESET_CTL, 8'h01);
    chk(MCR_TIMER_COUNT_HIGH, 8'hff);
    repeat (2) @(posedge ref_clk);
    test_done();
  end
endmodule
bind mcr_regs mcr_regs_asserts #(.LARGE_RAM(LARGE_RAM)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rdata(rdata), .flag_op(flag_op), .alu_carry(alu_carry),
  .alu_half_carry(alu_half_carry), .shifter_busy(shifter_busy),
  .int_request(int_request), .timer_run(timer_run),
  .timer_value(timer_value),
  .supervisor_reset_enable(supervisor_reset_enable));
